// file: pkg/swbm_pkg.sv
// constants and types for the sram write lane-mask block
package swbm_pkg;

   typedef enum logic [1:0] {
      SWBM_ORG_X8,
      SWBM_ORG_X9,
      SWBM_ORG_X18,
      SWBM_ORG_X36
   } swbm_org_t;

   // widest data word and lane geometry
   localparam int SWBM_DATA_W = 36;
   localparam int SWBM_SEL_W = 4;
   localparam int SWBM_NIB_W = 4;
   localparam int SWBM_LANE_W = 9;
   localparam int SWBM_LANE0_LSB = 0;
   localparam int SWBM_LANE1_LSB = 9;
   localparam int SWBM_LANE2_LSB = 18;
   localparam int SWBM_LANE3_LSB = 27;
   localparam int SWBM_NIB0_LSB = 0;
   localparam int SWBM_NIB1_LSB = 4;

   // four beats per burst, two address bits for the beat index
   localparam int SWBM_BURST_LEN = 4;
   localparam int SWBM_BEAT_W = 2;

   // synchroniser depth on every pin
   localparam int SWBM_SYNC_STAGES = 2;

   localparam logic [SWBM_BEAT_W-1:0] SWBM_BEAT0 = 2'h0;
   localparam logic [SWBM_BEAT_W-1:0] SWBM_BEAT1 = 2'h1;
   localparam logic [SWBM_BEAT_W-1:0] SWBM_BEAT2 = 2'h2;
   localparam logic [SWBM_BEAT_W-1:0] SWBM_BEAT3 = 2'h3;

endpackage

// file: rtl/swbm_lane_mask.sv
// lane select to bit write-enable decoder
`timescale 1ns/10ps
module swbm_lane_mask #(
   parameter swbm_pkg::swbm_org_t ORG = swbm_pkg::SWBM_ORG_X18
) (
   // active-low selects of one beat
   input wire logic [swbm_pkg::SWBM_SEL_W-1:0] i_sel_n,
   // per-bit write enable
   output logic [swbm_pkg::SWBM_DATA_W-1:0] o_mask
);

   function automatic logic [swbm_pkg::SWBM_DATA_W-1:0] lane_bits(
      input logic sel_n,
      input int lsb,
      input int width
   );
      logic [swbm_pkg::SWBM_DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < swbm_pkg::SWBM_DATA_W; b++) begin
         if (b >= lsb && b < lsb + width) begin
            m[b] = ~sel_n;
         end
      end
      return m;
   endfunction

   always_comb begin
      unique case (ORG)
         swbm_pkg::SWBM_ORG_X8: begin
            o_mask = lane_bits(i_sel_n[0], swbm_pkg::SWBM_NIB0_LSB, swbm_pkg::SWBM_NIB_W)
                   | lane_bits(i_sel_n[1], swbm_pkg::SWBM_NIB1_LSB, swbm_pkg::SWBM_NIB_W);
         end
         swbm_pkg::SWBM_ORG_X9: begin
            o_mask = lane_bits(i_sel_n[0], swbm_pkg::SWBM_LANE0_LSB, swbm_pkg::SWBM_LANE_W);
         end
         swbm_pkg::SWBM_ORG_X18: begin
            o_mask = lane_bits(i_sel_n[0], swbm_pkg::SWBM_LANE0_LSB, swbm_pkg::SWBM_LANE_W)
                   | lane_bits(i_sel_n[1], swbm_pkg::SWBM_LANE1_LSB, swbm_pkg::SWBM_LANE_W);
         end
         swbm_pkg::SWBM_ORG_X36: begin
            o_mask = lane_bits(i_sel_n[0], swbm_pkg::SWBM_LANE0_LSB, swbm_pkg::SWBM_LANE_W)
                   | lane_bits(i_sel_n[1], swbm_pkg::SWBM_LANE1_LSB, swbm_pkg::SWBM_LANE_W)
                   | lane_bits(i_sel_n[2], swbm_pkg::SWBM_LANE2_LSB, swbm_pkg::SWBM_LANE_W)
                   | lane_bits(i_sel_n[3], swbm_pkg::SWBM_LANE3_LSB, swbm_pkg::SWBM_LANE_W);
         end
      endcase
   end

endmodule

// file: rtl/swbm_write_port.sv
// ddr write port: burst sequencing, per-beat lane masking and storage array
`timescale 1ns/10ps
module swbm_write_port #(
   parameter swbm_pkg::swbm_org_t ORG = swbm_pkg::SWBM_ORG_X18,
   parameter int ADDR_W = 6
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // link pins, asynchronous to i_mclk
   input wire logic i_k_true,
   input wire logic i_k_comp,
   input wire logic i_wr_port_sel_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [swbm_pkg::SWBM_DATA_W-1:0] i_wdata,
   input wire logic i_lane0_write_sel_n,
   input wire logic i_lane1_write_sel_n,
   input wire logic i_lane2_write_sel_n,
   input wire logic i_lane3_write_sel_n,
   input wire logic i_low_half_write_sel_n,
   input wire logic i_high_half_write_sel_n,
   // inspection port on i_mclk
   input wire logic [ADDR_W+swbm_pkg::SWBM_BEAT_W-1:0] i_peek_addr,
   output logic [swbm_pkg::SWBM_DATA_W-1:0] o_peek_data,
   // beat report
   output logic o_beat_wr,
   output logic [ADDR_W+swbm_pkg::SWBM_BEAT_W-1:0] o_beat_addr,
   output logic [swbm_pkg::SWBM_DATA_W-1:0] o_beat_mask,
   output logic o_busy
);

   localparam int DW = swbm_pkg::SWBM_DATA_W;
   localparam int SW = swbm_pkg::SWBM_SEL_W;
   localparam int BW = swbm_pkg::SWBM_BEAT_W;
   localparam int IW = ADDR_W + BW;
   localparam int NS = swbm_pkg::SWBM_SYNC_STAGES;
   localparam int PW = 2 + 1 + ADDR_W + DW + SW;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ARMED,
      ST_BEAT1,
      ST_BEAT2,
      ST_BEAT3
   } swbm_state_t;

   // pin synchronisers, every pin through two flops
   logic [PW-1:0] pins_raw;
   logic [PW-1:0] sync0_reg;
   logic [PW-1:0] sync1_reg;
   logic kt_prev_reg;
   logic kc_prev_reg;

   always_comb begin
      if (ORG == swbm_pkg::SWBM_ORG_X8) begin
         pins_raw = {i_k_true, i_k_comp, i_wr_port_sel_n, i_addr, i_wdata,
                     2'h3, i_high_half_write_sel_n, i_low_half_write_sel_n};
      end else begin
         pins_raw = {i_k_true, i_k_comp, i_wr_port_sel_n, i_addr, i_wdata,
                     i_lane3_write_sel_n, i_lane2_write_sel_n,
                     i_lane1_write_sel_n, i_lane0_write_sel_n};
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync0_reg <= {PW{1'b1}};
         sync1_reg <= {PW{1'b1}};
         kt_prev_reg <= 1'b1;
         kc_prev_reg <= 1'b1;
      end else begin
         sync0_reg <= pins_raw;
         sync1_reg <= sync0_reg;
         kt_prev_reg <= sync1_reg[PW-1];
         kc_prev_reg <= sync1_reg[PW-2];
      end
   end

   logic kt_s;
   logic kc_s;
   logic wps_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DW-1:0] data_s;
   logic [SW-1:0] sel_n_s;
   logic kt_rise;
   logic kc_rise;

   assign kt_s = sync1_reg[PW-1];
   assign kc_s = sync1_reg[PW-2];
   assign wps_n_s = sync1_reg[PW-3];
   assign addr_s = sync1_reg[DW+SW+ADDR_W-1:DW+SW];
   assign data_s = sync1_reg[DW+SW-1:SW];
   assign sel_n_s = sync1_reg[SW-1:0];
   // one beat per rising edge of either input clock
   assign kt_rise = kt_s & ~kt_prev_reg;
   assign kc_rise = kc_s & ~kc_prev_reg;

   // selects decoded fresh on every edge
   logic [DW-1:0] beat_mask;

   swbm_lane_mask #(
      .ORG(ORG)
   ) u_lane_mask (
      .i_sel_n(sel_n_s),
      .o_mask(beat_mask)
   );

   // burst sequencer
   swbm_state_t state_reg;
   swbm_state_t state_next;
   logic prev_init_reg;
   logic prev_init_next;
   logic [ADDR_W-1:0] burst_addr_reg;
   logic [ADDR_W-1:0] burst_addr_next;
   logic pend_reg;
   logic pend_next;
   logic [ADDR_W-1:0] pend_addr_reg;
   logic [ADDR_W-1:0] pend_addr_next;
   logic init;
   logic beat_en;
   logic [BW-1:0] beat_idx;

   // a second start on the next true-clock rise is ignored
   assign init = kt_rise & ~wps_n_s & ~prev_init_reg;

   always_comb begin
      state_next = state_reg;
      burst_addr_next = burst_addr_reg;
      pend_next = pend_reg;
      pend_addr_next = pend_addr_reg;
      prev_init_next = prev_init_reg;
      beat_en = 1'b0;
      beat_idx = swbm_pkg::SWBM_BEAT0;
      if (kt_rise) begin
         prev_init_next = init;
      end
      unique case (state_reg)
         ST_IDLE: begin
            // no burst: selects on any edge are ignored
            if (init) begin
               state_next = ST_ARMED;
               burst_addr_next = addr_s;
            end
         end
         ST_ARMED: begin
            if (kt_rise) begin
               beat_en = 1'b1;
               beat_idx = swbm_pkg::SWBM_BEAT0;
               state_next = ST_BEAT1;
            end
         end
         ST_BEAT1: begin
            if (kc_rise) begin
               beat_en = 1'b1;
               beat_idx = swbm_pkg::SWBM_BEAT1;
               state_next = ST_BEAT2;
            end
         end
         ST_BEAT2: begin
            if (kt_rise) begin
               beat_en = 1'b1;
               beat_idx = swbm_pkg::SWBM_BEAT2;
               state_next = ST_BEAT3;
               if (init) begin
                  pend_next = 1'b1;
                  pend_addr_next = addr_s;
               end
            end
         end
         ST_BEAT3: begin
            if (kc_rise) begin
               beat_en = 1'b1;
               beat_idx = swbm_pkg::SWBM_BEAT3;
               pend_next = 1'b0;
               if (pend_reg) begin
                  state_next = ST_ARMED;
                  burst_addr_next = pend_addr_reg;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         burst_addr_reg <= '0;
         pend_reg <= 1'b0;
         pend_addr_reg <= '0;
         prev_init_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         burst_addr_reg <= burst_addr_next;
         pend_reg <= pend_next;
         pend_addr_reg <= pend_addr_next;
         prev_init_reg <= prev_init_next;
      end
   end

   // storage: each burst address holds four words
   logic [DW-1:0] mem [0:(1<<IW)-1];
   logic [IW-1:0] wr_idx;
   logic [DW-1:0] wr_word;

   assign wr_idx = {burst_addr_reg, beat_idx};
   // masked lanes keep their old contents
   assign wr_word = (mem[wr_idx] & ~beat_mask) | (data_s & beat_mask);

   always_ff @(posedge i_mclk) begin
      if (beat_en) begin
         mem[wr_idx] <= wr_word;
      end
   end

   // beat report and inspection outputs
   logic beat_wr_next;
   logic [IW-1:0] beat_addr_next;
   logic [DW-1:0] beat_mask_next;
   logic beat_wr_reg;
   logic [IW-1:0] beat_addr_reg;
   logic [DW-1:0] beat_mask_reg;
   logic [DW-1:0] peek_reg;
   logic busy_reg;

   always_comb begin
      beat_wr_next = beat_en;
      beat_addr_next = beat_en ? wr_idx : beat_addr_reg;
      beat_mask_next = beat_en ? beat_mask : beat_mask_reg;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         beat_wr_reg <= 1'b0;
         beat_addr_reg <= '0;
         beat_mask_reg <= '0;
         peek_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         beat_wr_reg <= beat_wr_next;
         beat_addr_reg <= beat_addr_next;
         beat_mask_reg <= beat_mask_next;
         peek_reg <= mem[i_peek_addr];
         busy_reg <= (state_next != ST_IDLE);
      end
   end

   assign o_beat_wr = beat_wr_reg;
   assign o_beat_addr = beat_addr_reg;
   assign o_beat_mask = beat_mask_reg;
   assign o_peek_data = peek_reg;
   assign o_busy = busy_reg;

endmodule

// file: testbench/swbm_sva.sv
// assertions on the write port's beat report
`timescale 1ns/10ps
module swbm_sva #(
   parameter swbm_pkg::swbm_org_t ORG = swbm_pkg::SWBM_ORG_X18
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // link pins
   input wire logic i_k_true,
   input wire logic i_k_comp,
   input wire logic i_lane0_write_sel_n,
   input wire logic i_lane1_write_sel_n,
   input wire logic i_lane2_write_sel_n,
   input wire logic i_lane3_write_sel_n,
   input wire logic i_low_half_write_sel_n,
   input wire logic i_high_half_write_sel_n,
   // beat report
   input wire logic o_beat_wr,
   input wire logic [swbm_pkg::SWBM_DATA_W-1:0] o_beat_mask,
   input wire logic o_busy
);
   logic [5:0] sel;
   logic [4:0] rose_reg;
   assign sel = {i_high_half_write_sel_n, i_low_half_write_sel_n, i_lane3_write_sel_n,
      i_lane2_write_sel_n, i_lane1_write_sel_n, i_lane0_write_sel_n};
   function automatic logic [35:0] lm(input logic [5:0] s);
      case (ORG)
         swbm_pkg::SWBM_ORG_X8: return {28'h0, {4{~s[5]}}, {4{~s[4]}}};
         swbm_pkg::SWBM_ORG_X9: return {27'h0, {9{~s[0]}}};
         swbm_pkg::SWBM_ORG_X18: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
         default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
      endcase
   endfunction
   // recent link clock rises
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rose_reg <= 5'h00;
      end else begin
         rose_reg <= {rose_reg[3:0], $rose(i_k_true) | $rose(i_k_comp)};
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_gap;
      !o_beat_wr [*2];
   endsequence
   beat_gap_a: assert property (o_beat_wr |=> s_gap)
      else $error("beat pulse not isolated");
   reset_quiet_a: assert property ($fell(i_rst) |-> !o_beat_wr && !o_busy)
      else $error("outputs active after reset");
   armed_write_a: assert property (o_beat_wr |-> $past(o_busy))
      else $error("beat written while idle");
   edge_cause_a: assert property (o_beat_wr |-> |rose_reg)
      else $error("beat without link clock rise");
   mask_map_a: assert property (o_beat_wr |->
      o_beat_mask == lm($past(sel, 3)) || o_beat_mask == lm($past(sel, 4)))
      else $error("beat mask differs from selects");
   mask_full_a: assert property (o_beat_wr && $past(sel, 3) == 6'h00
      && $past(sel, 4) == 6'h00 |-> o_beat_mask == lm(6'h00))
      else $error("full word not written");
   mask_none_a: assert property (o_beat_wr && $past(sel, 3) == 6'h3F
      && $past(sel, 4) == 6'h3F |-> o_beat_mask == 36'h0)
      else $error("write with all selects high");
   hold_report_a: assert property (!o_beat_wr |-> $stable(o_beat_mask))
      else $error("mask changed without beat");
endmodule
bind swbm_write_port swbm_sva #(.ORG(ORG)) i_sva (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_k_true(i_k_true), .i_k_comp(i_k_comp), .i_lane0_write_sel_n(i_lane0_write_sel_n),
   .i_lane1_write_sel_n(i_lane1_write_sel_n), .i_lane2_write_sel_n(i_lane2_write_sel_n),
   .i_lane3_write_sel_n(i_lane3_write_sel_n), .i_low_half_write_sel_n(i_low_half_write_sel_n),
   .i_high_half_write_sel_n(i_high_half_write_sel_n), .o_beat_wr(o_beat_wr),
   .o_beat_mask(o_beat_mask), .o_busy(o_busy));

// file: testbench/swbm_ctrl_model.sv
// memory-controller model driving the write link one clock level at a time
`timescale 1ns/10ps
module swbm_ctrl_model (
   // clock
   input wire logic i_mclk,
   // link pins
   output logic o_k_true,
   output logic o_k_comp,
   output logic o_wr_n,
   output logic [5:0] o_addr,
   output logic [35:0] o_wdata,
   output logic [5:0] o_sel_n
);
   // expected beats: {storage index, selects, data}
   logic [49:0] note_q[$];
   initial begin
      o_k_true = 1'b0;
      o_k_comp = 1'b1;
      o_wr_n = 1'b1;
      o_addr = 6'h00;
      o_wdata = 36'h0;
      o_sel_n = 6'h3F;
   end
   // pins settle one mclk before the edge and stand for 6 mclk; each clock level lasts 6 mclk
   task automatic half(input logic kt, input logic go, input logic [5:0] a,
         input logic dat, input logic [7:0] idx, input logic [5:0] s);
      @(posedge i_mclk);
      o_wr_n <= ~go;
      o_addr <= go ? a : 6'($urandom);
      o_wdata <= 36'({$urandom, $urandom});
      o_sel_n <= dat ? s : 6'($urandom);
      @(posedge i_mclk);
      o_k_true <= kt;
      o_k_comp <= ~kt;
      if (dat) note_q.push_back({idx, s, o_wdata});
      repeat (4) @(posedge i_mclk);
   endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench: four organisations share one write link
`timescale 1ns/10ps
module testbench;
   logic mclk, rst, k_t, k_c, wr_n;
   logic [5:0] addr, sel_n, nxt, cur;
   logic [35:0] wdata, m;
   logic [7:0] peek;
   logic beat_wr [4];
   logic busy [4];
   logic [7:0] beat_addr [4];
   logic [35:0] beat_mask [4], peek_data [4];
   logic [35:0] sh [4][16];
   logic [49:0] nt;
   int error_cnt = 0;
   int cmp_count = 0;
   swbm_ctrl_model i_ctrl (.i_mclk(mclk), .o_k_true(k_t), .o_k_comp(k_c), .o_wr_n(wr_n),
      .o_addr(addr), .o_wdata(wdata), .o_sel_n(sel_n));
   for (genvar g = 0; g < 4; g++) begin : g_org
      swbm_write_port #(.ORG(swbm_pkg::swbm_org_t'(g))) i_dut (.i_mclk(mclk), .i_rst(rst),
         .i_k_true(k_t), .i_k_comp(k_c), .i_wr_port_sel_n(wr_n), .i_addr(addr),
         .i_wdata(wdata), .i_lane0_write_sel_n(sel_n[0]), .i_lane1_write_sel_n(sel_n[1]),
         .i_lane2_write_sel_n(sel_n[2]), .i_lane3_write_sel_n(sel_n[3]),
         .i_low_half_write_sel_n(sel_n[4]), .i_high_half_write_sel_n(sel_n[5]),
         .i_peek_addr(peek), .o_peek_data(peek_data[g]), .o_beat_wr(beat_wr[g]),
         .o_beat_addr(beat_addr[g]), .o_beat_mask(beat_mask[g]), .o_busy(busy[g]));
   end
   function automatic logic [35:0] emask(input int g, input logic [5:0] s);
      case (g)
         0: return {28'h0, {4{~s[5]}}, {4{~s[4]}}};
         1: return {27'h0, {9{~s[0]}}};
         2: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
         default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
      endcase
   endfunction
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // one link clock period; go starts a write burst at the true-clock rise
   task automatic pair(input logic go, input logic [5:0] a);
      i_ctrl.half(1'b1, go, a, 1'b0, 8'h00, 6'h00);
      i_ctrl.half(1'b0, 1'b0, a, 1'b0, 8'h00, 6'h00);
   endtask
   // four beats; select code steps per beat when st is set
   task automatic burst(input logic [5:0] a, input logic [3:0] c, input logic st,
         input logic dup, input logic nx, input logic [5:0] na);
      logic [3:0] cb;
      for (int b = 0; b < 4; b++) begin
         cb = c + 4'(st ? b : 0);
         i_ctrl.half(b % 2 == 0, (b == 0 && dup) || (b == 2 && nx),
            b == 0 ? 6'($urandom_range(3)) : na, 1'b1, {a, 2'(b)}, {cb[1:0], cb});
      end
   endtask
   task automatic peek_all();
      for (int i = 0; i < 16; i++) begin
         @(posedge mclk);
         peek <= 8'(i);
         repeat (2) @(posedge mclk);
         for (int g = 0; g < 4; g++) begin
            chk(peek_data[g] & emask(g, 6'h00), sh[g][i] & emask(g, 6'h00));
            chk(36'(busy[g]), 36'h0);
         end
      end
   endtask
   always @(posedge mclk) begin
      if (beat_wr[3] === 1'b1) begin
         if (i_ctrl.note_q.size() == 0) begin
            chk(36'h1, 36'h0);
         end else begin
            nt = i_ctrl.note_q.pop_front();
            for (int g = 0; g < 4; g++) begin
               m = emask(g, nt[41:36]);
               chk(36'(beat_wr[g]), 36'h1);
               chk(36'(beat_addr[g]), 36'(nt[49:42]));
               chk(beat_mask[g], m);
               sh[g][nt[45:42]] = (sh[g][nt[45:42]] & ~m) | (nt[35:0] & m);
            end
         end
      end
   end
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // the whole run needs about 10 us
   initial begin
      #100us;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(12));
      rst = 1'b1;
      peek = 8'h00;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      pair(1'b0, 6'h00);
      // full words to locations 0..3, each burst after the first started during the one before
      pair(1'b1, 6'h00);
      for (int i = 0; i < 4; i++) burst(6'(i), 4'h0, 1'b0, 1'b0, i < 3, 6'(i + 1));
      pair(1'b0, 6'h00);
      peek_all();
      $display("test full_word done");
      // all sixteen select codes over four chained bursts
      nxt = 6'($urandom_range(3));
      pair(1'b1, nxt);
      for (int i = 0; i < 4; i++) begin
         cur = nxt;
         nxt = 6'($urandom_range(3));
         burst(cur, 4'(4 * i), 1'b1, 1'b0, i < 3, nxt);
      end
      pair(1'b0, 6'h00);
      peek_all();
      $display("test select_codes done");
      // all selects high, then a second start on the first data edge
      pair(1'b1, 6'h02);
      for (int g = 0; g < 4; g++) chk(36'(busy[g]), 36'h1);
      burst(6'h02, 4'hF, 1'b0, 1'b0, 1'b0, 6'h00);
      pair(1'b1, 6'h01);
      burst(6'h01, 4'h6, 1'b1, 1'b1, 1'b0, 6'h00);
      pair(1'b0, 6'h00);
      pair(1'b0, 6'h00);
      peek_all();
      chk(36'(i_ctrl.note_q.size()), 36'h0);
      $display("test refusals done");
      report_and_stop();
   end
endmodule
